// file: hw/csf_consts.svh
// How it works
// RULE1: Forever-loop flag set when unbounded loop starts.
// RULE2: Forever-loop flag restored from stack on exit/return.
// RULE3: Loop flag marks loop; restored on exit/return.
// RULE4: Double-precision bit drives multiply mode output.
// RULE5: Compat mode zeroes upper byte of control moves.
// RULE6: Compat mode: status source zeroed, destination kept.
// RULE7: Without compat mode, zero count skips loop.
// RULE8: Compat bit change acts after three cycles.
// RULE9: Extension flag clear when integer part uniform.
// RULE10: Scaling bits choose integer portion bits.
// RULE11: Negative flag follows result sign bit.
// RULE12: Zero flag set when result is zero.
// RULE13: Overflow flag set on 56-bit overflow; the code sets V only in saturation mode and clears it otherwise.
// RULE14: Saturation mode overflow checks 48/32-bit range.
// RULE15: Carry flag from bit 55 carry/borrow.
// RULE16: Carry also updated by bit/shift/rotate ops.
// RULE17: Unnormalized flag is XNOR below integer portion.
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH
`define CSF_BIT_C 0
`define CSF_BIT_V 1
`define CSF_BIT_Z 2
`define CSF_BIT_N 3
`define CSF_BIT_U 4
`define CSF_BIT_E 5
`define CSF_BIT_S0 10
`define CSF_BIT_S1 11
`define CSF_BIT_SC 13
`define CSF_BIT_DM 14
`define CSF_BIT_LF 15
`define CSF_BIT_FV 16
`define CSF_SR_RESET 24'h000020
`define CSF_COMPAT_DELAY 3
`define CSF_HI_MASK 24'hff0000
`endif

// file: hw/csf_pkg.sv
package csf_pkg;
   typedef enum logic [1:0] {
      CSF_SCALE_NONE,
      CSF_SCALE_DOWN,
      CSF_SCALE_UP,
      CSF_SCALE_RSVD
   } csf_scale_t;
   typedef enum logic [1:0] {
      CSF_MV_NONE,
      CSF_MV_CTRL,
      CSF_MV_FROM_STAT,
      CSF_MV_TO_STAT
   } csf_move_t;
endpackage

// file: hw/csf_status_flags.sv
`timescale 1ns/1ps
`include "csf_consts.svh"
module csf_status_flags
   import csf_pkg::*;
(
   // Clock and reset.
   input wire logic refClk,
   input wire logic rst_n,
   // Arithmetic result and flag update controls.
   input wire logic [55:0] aluResult,
   input wire logic aluUpdate,
   input wire logic aluCarry,
   input wire logic carryUpdate,
   input wire logic shiftCarry,
   input wire logic satMode,
   input wire logic sixteenBitMode,
   // Loop control from program control unit.
   input wire logic foreverStart,
   input wire logic loopStart,
   input wire logic loopExit,
   input wire logic interruptReturn,
   input wire logic stackFv,
   input wire logic stackLf,
   input wire logic [23:0] loopCount,
   // Move datapath.
   input wire logic [1:0] moveKind,
   input wire logic [23:0] moveData,
   input wire logic [23:0] moveOldDest,
   // Register port.
   input wire logic [3:0] regAddr,
   input wire logic [23:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   // Outputs.
   output logic [23:0] regRdata,
   output logic [23:0] coreStatusWord,
   output logic [23:0] moveResult,
   output logic loopSkip,
   output logic doublePrecisionMode,
   output logic compatModeEff
);
   logic [23:0] srR;
   logic [`CSF_COMPAT_DELAY-1:0] compatPipeR;
   logic [55:0] mag;
   logic eNxt, uNxt, vNxt;
   csf_scale_t scale;

   // ==========================================================
   // Flag evaluation.
   always_comb begin
      scale = csf_scale_t'({srR[`CSF_BIT_S1], srR[`CSF_BIT_S0]});
      mag = aluResult;
      case (scale) // [RULE10]
         CSF_SCALE_NONE: begin
            eNxt = !((&aluResult[55:47]) || !(|aluResult[55:47])); // [RULE9]
            uNxt = !(aluResult[47] ^ aluResult[46]); // [RULE17]
         end
         CSF_SCALE_DOWN: begin
            eNxt = !((&aluResult[55:48]) || !(|aluResult[55:48])); // [RULE9]
            uNxt = !(aluResult[48] ^ aluResult[47]); // [RULE17]
         end
         CSF_SCALE_UP: begin
            eNxt = !((&aluResult[55:46]) || !(|aluResult[55:46]));
            uNxt = !(aluResult[46] ^ aluResult[45]);
         end
         default: begin
            eNxt = 1'b0;
            uNxt = 1'b0;
         end
      endcase
      if (satMode && sixteenBitMode) begin
         vNxt = !((&mag[55:31]) || !(|mag[55:31])); // [RULE14]
      end else if (satMode) begin
         vNxt = !((&mag[55:47]) || !(|mag[55:47])); // [RULE14]
      end else begin
         vNxt = 1'b0;
      end
   end

   // ==========================================================
   // Status register.
   always_ff @(posedge refClk) begin
      if (!rst_n) begin
         srR <= `CSF_SR_RESET; // [RULE9]
      end else begin
         if (regWr && regAddr == 4'h0) begin
            srR <= regWdata;
         end
         if (aluUpdate) begin
            srR[`CSF_BIT_E] <= eNxt;
            srR[`CSF_BIT_U] <= uNxt;
            srR[`CSF_BIT_N] <= aluResult[55]; // [RULE11]
            srR[`CSF_BIT_Z] <= (aluResult == 56'h0); // [RULE12]
            srR[`CSF_BIT_V] <= vNxt; // [RULE13]
            srR[`CSF_BIT_C] <= aluCarry; // [RULE15]
         end
         if (carryUpdate) begin
            srR[`CSF_BIT_C] <= shiftCarry; // [RULE16]
         end
         if (loopExit || interruptReturn) begin
            srR[`CSF_BIT_FV] <= stackFv; // [RULE2]
            srR[`CSF_BIT_LF] <= stackLf; // [RULE3]
         end
         if (foreverStart) begin
            srR[`CSF_BIT_FV] <= 1'b1; // [RULE1]
            srR[`CSF_BIT_LF] <= 1'b1; // [RULE3]
         end
         if (loopStart) begin
            srR[`CSF_BIT_LF] <= 1'b1; // [RULE3]
         end
      end
   end

   // ==========================================================
   // Compatibility mode delay pipeline.
   always_ff @(posedge refClk) begin
      if (!rst_n) begin
         compatPipeR <= '0;
      end else begin
         compatPipeR <= {compatPipeR[`CSF_COMPAT_DELAY-2:0], srR[`CSF_BIT_SC]}; // [RULE8]
      end
   end

   // ==========================================================
   // Move result and loop skip.
   always_ff @(posedge refClk) begin
      if (!rst_n) begin
         moveResult <= 24'h0;
      end else begin
         case (csf_move_t'(moveKind))
            CSF_MV_CTRL: begin
               moveResult <= compatModeEff ? (moveData & ~`CSF_HI_MASK) : moveData; // [RULE5]
            end
            CSF_MV_FROM_STAT: begin
               moveResult <= compatModeEff ? (moveData & ~`CSF_HI_MASK) : moveData; // [RULE6]
            end
            CSF_MV_TO_STAT: begin
               moveResult <= compatModeEff ?
                  ((moveOldDest & `CSF_HI_MASK) | (moveData & ~`CSF_HI_MASK)) : moveData; // [RULE6]
            end
            default: begin
               moveResult <= moveData;
            end
         endcase
      end
   end

   always_ff @(posedge refClk) begin
      if (!rst_n) begin
         regRdata <= 24'h0;
      end else if (regRd) begin
         regRdata <= (regAddr == 4'h0) ? srR : 24'h0;
      end
   end

   assign loopSkip = !compatModeEff && (loopCount == 24'h0); // [RULE7]
   assign compatModeEff = compatPipeR[`CSF_COMPAT_DELAY-1];
   assign doublePrecisionMode = srR[`CSF_BIT_DM]; // [RULE4]
   assign coreStatusWord = srR;
endmodule

// file: tb/csf_status_flags_asserts.sv
`timescale 1ns/1ps
module csf_status_flags_asserts (
   // Clock and causes.
   input wire logic refClk,
   input wire logic rst_n,
   input wire logic [55:0] aluResult,
   input wire logic aluUpdate,
   input wire logic aluCarry,
   input wire logic carryUpdate,
   input wire logic shiftCarry,
   input wire logic foreverStart,
   input wire logic loopStart,
   input wire logic loopExit,
   input wire logic stackFv,
   input wire logic stackLf,
   input wire logic [1:0] moveKind,
   // Results.
   input wire logic [23:0] coreStatusWord,
   input wire logic [23:0] moveResult,
   input wire logic doublePrecisionMode,
   input wire logic compatModeEff
);
   default clocking @(posedge refClk); endclocking
   default disable iff (!rst_n);
   wire quiet = !(foreverStart || loopStart || loopExit);
   a_forever_set: assert property (foreverStart |=> coreStatusWord[16:15] == 2'h3)
      else $error("loop flags not set");
   a_stack_restore: assert property (loopExit && quiet | loopExit && !foreverStart && !loopStart
      |=> coreStatusWord[16:15] == $past({stackFv, stackLf})) else $error("no restore");
   a_dm_output: assert property (doublePrecisionMode == coreStatusWord[14])
      else $error("dm output wrong");
   a_compat_lag: assert property (compatModeEff == $past(coreStatusWord[13], 3))
      else $error("compat lag wrong");
   a_move_ctrl: assert property (moveKind == 2'h1 && compatModeEff |=> moveResult[23:16] == 8'h0)
      else $error("upper byte kept");
   a_sign_zero: assert property (aluUpdate && quiet |=>
      coreStatusWord[3:2] == {$past(aluResult[55]), $past(aluResult) == 56'h0}) else $error("n z");
   a_alu_carry: assert property (aluUpdate && quiet |=> coreStatusWord[0] == $past(aluCarry))
      else $error("carry wrong");
   a_shift_carry: assert property (carryUpdate && !aluUpdate && quiet |=>
      coreStatusWord[0] == $past(shiftCarry)) else $error("shift carry wrong");
endmodule
bind csf_status_flags csf_status_flags_asserts csf_status_flags_asserts_inst (.*);

// file: tb/csf_pcu_model.sv
`timescale 1ns/1ps
module csf_pcu_model (
   // Core side.
   input wire logic refClk,
   input wire logic foreverStart,
   input wire logic loopStart,
   input wire logic [23:0] coreStatusWord,
   // Stacked loop flags.
   output logic stackFv = 1'b0,
   output logic stackLf = 1'b0
);
   // One-deep stack: the flags are pushed as a loop opens.
   always_ff @(posedge refClk) begin
      if (foreverStart || loopStart) begin
         {stackFv, stackLf} <= coreStatusWord[16:15];
      end
   end
endmodule

// file: tb/csf_status_flags_tb.sv
`timescale 1ns/1ps
module csf_status_flags_tb;
   logic refClk = 0, rst_n = 0, aluCarry = 0, shiftCarry = 0, satMode = 0, sixteenBitMode = 0;
   logic stackFv, stackLf, loopSkip, doublePrecisionMode, compatModeEff;
   logic [9:0] ctl = 10'h0;
   wire foreverStart, loopStart, loopExit, interruptReturn, aluUpdate, carryUpdate, regWr, regRd;
   wire [1:0] moveKind;
   logic [55:0] aluResult = 56'h0;
   logic [55:0] vals[5] = '{56'h0, 56'hff800000000000, 56'h00400000000000, 56'h01000000000001,
      56'h00800000000000};
   logic [3:0] regAddr = 4'h0;
   logic [23:0] loopCount = 24'h0, moveData = 24'h0, moveOldDest = 24'h987654, regWdata = 24'h0;
   logic [23:0] regRdata, coreStatusWord, moveResult;
   int error_cnt = 0, compares = 0;
   assign {foreverStart, loopStart, loopExit, interruptReturn, aluUpdate, carryUpdate, regWr,
      regRd, moveKind} = ctl;
   csf_status_flags csf_status_flags_inst (.*);
   csf_pcu_model csf_pcu_model_inst (.*);
   initial forever #12.5 refClk = ~refClk;
   function automatic logic [5:0] flags(logic [55:0] r, logic s, logic sat, logic c);
      logic [8:0] ip = s ? {r[55], r[55:48]} : r[55:47];
      return {!(&ip || ~|ip), s ? r[48] ~^ r[47] : r[47] ~^ r[46], r[55], r == 56'h0,
         sat && !(&r[55:47] || ~|r[55:47]), c};
   endfunction
   task automatic chk(logic [55:0] seen, logic [55:0] exp, string what);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Pulses the strobes for one cycle; one data bus feeds aluResult, regWdata and moveData.
   task automatic go(logic [9:0] m, logic [55:0] d = 56'h0, logic [3:0] a = 4'h0);
      @(posedge refClk);
      ctl <= m;
      aluResult <= d;
      regWdata <= d[23:0];
      moveData <= d[23:0];
      regAddr <= a;
      @(posedge refClk);
      ctl <= 10'h0;
      #1;
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge refClk);
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge refClk);
      rst_n <= 1;
      go(10'h004);
      chk(regRdata, 24'h000020, "status reset");
      go(10'h008, 56'hffffff, 4'h3);
      go(10'h004, 56'h0, 4'h3);
      chk(regRdata, 24'h0, "unmapped read");
      $display("register test done");
      chk(loopSkip, 1, "zero count skip");
      @(posedge refClk) loopCount <= 24'h000005;
      #1 chk(loopSkip, 0, "count skip");
      for (int i = 0; i < 10; i++) begin
         go(10'h008, {i[0], 10'h0});
         satMode <= i > 7;
         aluCarry <= i[1];
         go(10'h020, vals[i % 5]);
         chk(coreStatusWord[5:0], flags(vals[i % 5], i[0], i > 7, i[1]), "alu");
      end
      sixteenBitMode <= 1;
      satMode <= 1;
      go(10'h020, 56'h00000080000000);
      chk(coreStatusWord[1], 1, "sixteen-bit overflow");
      sixteenBitMode <= 0;
      shiftCarry <= 1;
      go(10'h010);
      chk(coreStatusWord[0], 1, "shift carry");
      $display("flag test done");
      go(10'h100);
      chk(coreStatusWord[16:15], 2'h1, "loop flags");
      go(10'h200);
      chk(coreStatusWord[16:15], 2'h3, "forever flags");
      go(10'h040);
      chk(coreStatusWord[16:15], 2'h1, "return flags");
      go(10'h080);
      chk(coreStatusWord[16:15], 2'h1, "exit flags");
      $display("loop test done");
      go(10'h008, 56'h006000);
      chk(doublePrecisionMode, 1, "double mode");
      repeat (2) @(posedge refClk);
      #1 chk(compatModeEff, 0, "compat early");
      @(posedge refClk);
      #1 chk(compatModeEff, 1, "compat on");
      go(10'h001, 56'habcdef);
      chk(moveResult, 24'h00cdef, "ctrl move");
      go(10'h002, 56'h123456);
      chk(moveResult, 24'h003456, "status source");
      go(10'h003, 56'h123456);
      chk(moveResult, 24'h983456, "status dest");
      $display("mode test done");
      test_done();
   end
endmodule
